// File: shared/soc_bus_pkg.sv
// Purpose: Shared constants and types for the single/block bus cycle ends
// Assumes: One clock, mclk at 100 MHz; active-low asynchronous reset rst_b
package soc_bus_pkg;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int TAG_W = 1;
    localparam int MEM_DEPTH = 256;
    localparam int WAIT_W = 4;
    localparam int BLEN_W = 8;
    localparam logic [TAG_W-1:0] TAG_START = 1'h1;
    localparam int BYTE_W = 8;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_ONE_CNT = 4'h1;
    localparam logic [BLEN_W-1:0] BLEN_ONE = 8'h1;
    localparam logic [ADR_W-1:0] ADR_STEP = 8'h1;
    localparam logic [ADR_W-1:0] ERR_ADR = 8'hff;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_BEAT = 4'h2,
        M_GAP  = 4'h4,
        M_DONE = 4'h8
    } mst_state_t;
endpackage

// File: shared/soc_bus_if.sv
// Purpose: Link between master end and slave end
// Assumes: Both ends on mclk
// Notes:   Plain signals, no clocking block
`timescale 1ns/100ps
`default_nettype none
interface soc_bus_if;
    logic                           cyc;      // Cycle held for the whole transfer
    logic                           stb;      // Strobe qualifying one beat
    logic                           we;       // Write enable
    logic [soc_bus_pkg::ADR_W-1:0]  adr;      // Address
    logic [soc_bus_pkg::SEL_W-1:0]  sel;      // Byte selects
    logic [soc_bus_pkg::TAG_W-1:0]  tag_m;    // Master tag
    logic [soc_bus_pkg::DAT_W-1:0]  dat_m;    // Write data
    logic [soc_bus_pkg::DAT_W-1:0]  dat_s;    // Read data
    logic [soc_bus_pkg::TAG_W-1:0]  tag_s;    // Slave tag
    logic                           ack;      // Normal termination
    logic                           err;      // Error termination
    logic                           rty;      // Retry termination

    modport master (output cyc, stb, we, adr, sel, tag_m, dat_m,
                    input dat_s, tag_s, ack, err, rty);
    modport slave  (input cyc, stb, we, adr, sel, tag_m, dat_m,
                    output dat_s, tag_s, ack, err, rty);
endinterface
`default_nettype wire

// File: design/byte_lane_merge.sv
// Purpose: Merge write data into a stored word under byte selects
// Assumes: Byte granularity
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
module byte_lane_merge (
    input  wire logic [soc_bus_pkg::DAT_W-1:0] old_word,   // Stored word
    input  wire logic [soc_bus_pkg::DAT_W-1:0] new_word,   // Incoming data
    input  wire logic [soc_bus_pkg::SEL_W-1:0] sel,        // Byte selects
    output logic      [soc_bus_pkg::DAT_W-1:0] merged      // Result
);
    // One lane per select bit
    for (genvar i = 0; i < soc_bus_pkg::SEL_W; i++) begin : g_lane
        assign merged[i*soc_bus_pkg::BYTE_W +: soc_bus_pkg::BYTE_W] =
            sel[i] ? new_word[i*soc_bus_pkg::BYTE_W +: soc_bus_pkg::BYTE_W]
                   : old_word[i*soc_bus_pkg::BYTE_W +: soc_bus_pkg::BYTE_W];
    end
endmodule
`default_nettype wire

// File: design/bus_slave_end.sv
// Purpose: Slave end: small memory answering single and block cycles
// Assumes: Master keeps its side of the handshake
// Notes:   Responses are combinational from strobe
`timescale 1ns/100ps
`default_nettype none
module bus_slave_end (
    input  wire logic                          mclk,        // Clock
    input  wire logic                          rst_b,       // Async reset, low
    soc_bus_if.slave                           bus,         // Bus link
    input  wire logic [soc_bus_pkg::WAIT_W-1:0] wait_cfg,   // Wait states per beat
    output logic                               wr_pulse,    // Write taken
    output logic      [soc_bus_pkg::ADR_W-1:0] wr_adr       // Last written address
);
    typedef struct packed {
        logic [soc_bus_pkg::WAIT_W-1:0] wcnt;
        logic                           wr;
        logic [soc_bus_pkg::ADR_W-1:0]  wadr;
        logic [soc_bus_pkg::TAG_W-1:0]  tag;
    } slv_t;

    slv_t st_r;
    slv_t st_nxt;
    logic [soc_bus_pkg::DAT_W-1:0] mem [soc_bus_pkg::MEM_DEPTH];
    logic [soc_bus_pkg::DAT_W-1:0] merged;
    logic                          ready;
    logic                          bad;
    logic                          done;

    byte_lane_merge u_merge (
        .old_word (mem[bus.adr]),
        .new_word (bus.dat_m),
        .sel      (bus.sel),
        .merged   (merged)
    );

    // Ready once the wait counter reaches the configured count
    assign ready = (st_r.wcnt == wait_cfg);
    assign bad   = (bus.adr == soc_bus_pkg::ERR_ADR);
    // Terminations gated by cycle, strobe and the wait count; no clock in the path
    assign bus.ack = bus.cyc & bus.stb & ready & ~bad;
    assign bus.err = bus.cyc & bus.stb & ready & bad;
    assign bus.rty = 1'b0;
    assign done    = bus.ack | bus.err;
    assign bus.dat_s = mem[bus.adr];
    assign bus.tag_s = st_r.tag;
    assign wr_pulse  = st_r.wr;
    assign wr_adr    = st_r.wadr;

    // Next-state: count waits only while strobe is up
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr = 1'b0;
        if (!(bus.cyc && bus.stb)) begin
            st_nxt.wcnt = soc_bus_pkg::WAIT_ZERO;
        end else if (done) begin
            st_nxt.wcnt = soc_bus_pkg::WAIT_ZERO;
            st_nxt.tag  = bus.tag_m;
            if (bus.we && bus.ack) begin
                st_nxt.wr   = 1'b1;
                st_nxt.wadr = bus.adr;
            end
        end else begin
            st_nxt.wcnt = st_r.wcnt + soc_bus_pkg::WAIT_ONE_CNT;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Memory write on the acknowledged edge
    always_ff @(posedge mclk) begin
        if (bus.ack && bus.we) begin
            mem[bus.adr] <= merged;
        end
    end
endmodule
`default_nettype wire

// File: design/bus_master_end.sv
// Purpose: Master end issuing single and block cycles from a command port
// Assumes: Slave answers with combinational terminations
// Notes:   Strobe and cycle come straight from flops
`timescale 1ns/100ps
`default_nettype none
module bus_master_end (
    input  wire logic                           mclk,       // Clock
    input  wire logic                           rst_b,      // Async reset, low
    soc_bus_if.master                           bus,        // Bus link
    input  wire logic                           req,        // Start request
    input  wire logic                           req_we,     // Write when high
    input  wire logic [soc_bus_pkg::ADR_W-1:0]  req_adr,    // First address
    input  wire logic [soc_bus_pkg::SEL_W-1:0]  req_sel,    // Byte selects
    input  wire logic [soc_bus_pkg::BLEN_W-1:0] req_len,    // Beats, 1 = single
    input  wire logic [soc_bus_pkg::DAT_W-1:0]  wr_data,    // Write data for current beat
    input  wire logic                           hold,       // Insert master wait
    output logic                                busy,       // Cycle in progress
    output logic                                beat_done,  // Beat terminated
    output logic      [soc_bus_pkg::DAT_W-1:0]  rd_data,    // Captured read data
    output logic      [soc_bus_pkg::TAG_W-1:0]  rd_tag,     // Captured slave tag
    output logic                                fault       // Error or retry seen
);
    typedef struct packed {
        soc_bus_pkg::mst_state_t        fsm;
        logic                           cyc;
        logic                           stb;
        logic                           we;
        logic [soc_bus_pkg::ADR_W-1:0]  adr;
        logic [soc_bus_pkg::SEL_W-1:0]  sel;
        logic [soc_bus_pkg::TAG_W-1:0]  tag;
        logic [soc_bus_pkg::DAT_W-1:0]  dat;
        logic [soc_bus_pkg::BLEN_W-1:0] left;
        logic                           beat;
        logic [soc_bus_pkg::DAT_W-1:0]  rdat;
        logic [soc_bus_pkg::TAG_W-1:0]  rtag;
        logic                           flt;
    } mst_t;

    mst_t st_r;
    mst_t st_nxt;
    logic term;

    assign term      = bus.ack | bus.err | bus.rty;
    // Outputs taken straight from the state flops
    assign bus.cyc   = st_r.cyc;
    assign bus.stb   = st_r.stb;
    assign bus.we    = st_r.we;
    assign bus.adr   = st_r.adr;
    assign bus.sel   = st_r.sel;
    assign bus.tag_m = st_r.tag;
    assign bus.dat_m = st_r.dat;
    assign busy      = st_r.cyc;
    assign beat_done = st_r.beat;
    assign rd_data   = st_r.rdat;
    assign rd_tag    = st_r.rtag;
    assign fault     = st_r.flt;

    // Cycle sequencing
    always_comb begin
        st_nxt = st_r;
        st_nxt.beat = 1'b0;
        case (st_r.fsm)
            soc_bus_pkg::M_IDLE: begin
                if (req) begin
                    st_nxt.cyc  = 1'b1;
                    st_nxt.stb  = 1'b1;
                    st_nxt.we   = req_we;
                    st_nxt.adr  = req_adr;
                    st_nxt.sel  = req_sel;
                    st_nxt.tag  = soc_bus_pkg::TAG_START;
                    st_nxt.dat  = wr_data;
                    st_nxt.left = req_len;
                    st_nxt.flt  = 1'b0;
                    st_nxt.fsm  = soc_bus_pkg::M_BEAT;
                end
            end
            soc_bus_pkg::M_BEAT: begin
                if (term) begin
                    st_nxt.beat = 1'b1;
                    st_nxt.tag  = '0;
                    if (!st_r.we) begin
                        st_nxt.rdat = bus.dat_s;
                    end
                    st_nxt.rtag = bus.tag_s;
                    st_nxt.left = st_r.left - soc_bus_pkg::BLEN_ONE;
                    st_nxt.adr  = st_r.adr + soc_bus_pkg::ADR_STEP;
                    st_nxt.dat  = wr_data;
                    if (bus.err || bus.rty || st_r.left == soc_bus_pkg::BLEN_ONE) begin
                        st_nxt.flt = bus.err | bus.rty;
                        st_nxt.stb = 1'b0;
                        st_nxt.cyc = 1'b0;
                        st_nxt.fsm = soc_bus_pkg::M_DONE;
                    end else if (hold) begin
                        st_nxt.stb = 1'b0;
                        st_nxt.fsm = soc_bus_pkg::M_GAP;
                    end
                end
            end
            soc_bus_pkg::M_GAP: begin
                if (!hold) begin
                    st_nxt.stb = 1'b1;
                    st_nxt.dat = wr_data;
                    st_nxt.fsm = soc_bus_pkg::M_BEAT;
                end
            end
            soc_bus_pkg::M_DONE: begin
                st_nxt.fsm = soc_bus_pkg::M_IDLE;
            end
            default: begin
                st_nxt.fsm = soc_bus_pkg::M_IDLE;
                st_nxt.cyc = 1'b0;
                st_nxt.stb = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r     <= '0;
            st_r.fsm <= soc_bus_pkg::M_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// File: tb/soc_bus_cycle_chk.sv
// Purpose: Protocol checks on the link between the two ends
// Assumes: One clock; rst_b asynchronous, active low
// Notes:   Sees interface signals only, instantiated beside the link
`timescale 1ns/100ps
`default_nettype none
module soc_bus_cycle_chk (
    input wire logic                          mclk,  // Clock
    input wire logic                          rst_b, // Reset, low
    input wire logic                          cyc,   // Cycle
    input wire logic                          stb,   // Strobe
    input wire logic                          we,    // Write enable
    input wire logic [soc_bus_pkg::ADR_W-1:0] adr,   // Address
    input wire logic [soc_bus_pkg::TAG_W-1:0] tag_m, // Master tag
    input wire logic [soc_bus_pkg::DAT_W-1:0] dat_m, // Write data
    input wire logic                          ack,   // Acknowledge
    input wire logic                          err,   // Error
    input wire logic                          rty    // Retry
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Handshake checks
    // ----------------------------------------
    sequence beat_wait; stb && !ack && !err; endsequence
    sequence beat_end; stb && ack; endsequence
    a_term_needs_stb: assert property ((ack || err) |-> stb && cyc)
        else $error("termination seen without strobe");
    a_one_term: assert property (!(ack && err) && !rty)
        else $error("more than one termination");
    a_req_held: assert property (beat_wait |=> stb && $stable(adr) && $stable(we) && $stable(dat_m))
        else $error("request changed before termination");
    a_next_addr: assert property (beat_end ##1 stb |-> adr == $past(adr) + soc_bus_pkg::ADR_STEP && tag_m == 1'h0)
        else $error("next beat address or tag wrong");
    a_gap_keeps_cyc: assert property (cyc && !stb |=> cyc)
        else $error("cycle dropped inside a gap");
    a_end_both: assert property ($fell(cyc) |-> $fell(stb))
        else $error("cycle ended apart from strobe");
    a_start_tag: assert property ($rose(cyc) |-> stb && tag_m == soc_bus_pkg::TAG_START)
        else $error("cycle start without strobe and tag");
    a_err_addr: assert property (stb && adr == soc_bus_pkg::ERR_ADR |-> !ack)
        else $error("acknowledge on the error address");
    // Wait states come from a four bit count, so 16 cycles bound the wait
    a_wait_bound: assert property ($rose(stb) |-> ##[0:16] (ack || err))
        else $error("beat never terminated");
    // First reset edge may still show pre-reset flops, so look from the second one on
    a_reset_quiet: assert property (@(posedge mclk) disable iff (1'b0) !rst_b ##1 !rst_b |-> !cyc && !stb && !ack)
        else $error("bus active during reset");
endmodule
`default_nettype wire

// File: tb/soc_bus_single_block_cycles_tb.sv
// Purpose: Self-checking bench joining master end and slave end
// Assumes: mclk 100 MHz, rst_b held low for two cycles
// Notes:   Expected data comes from what the bench itself wrote
`timescale 1ns/100ps
`default_nettype none
module soc_bus_single_block_cycles_tb;
    logic        mclk;
    logic        rst_b;
    logic        req;
    logic        req_we;
    logic [7:0]  req_adr;
    logic [3:0]  req_sel;
    logic [7:0]  req_len;
    logic [31:0] wr_data;
    logic        hold;
    logic [3:0]  wait_cfg;
    logic        busy;
    logic        beat_done;
    logic [31:0] rd_data;
    logic [0:0]  rd_tag;
    logic        fault;
    logic        wr_pulse;
    logic [7:0]  wr_adr;
    logic [31:0] rdq[$];
    int          nwr;
    int          n_errors = 0;
    int          cmp_count = 0;
    soc_bus_if bus_if ();
    bus_master_end u_bus_master_end (.mclk(mclk), .rst_b(rst_b), .bus(bus_if.master), .req(req),
        .req_we(req_we), .req_adr(req_adr), .req_sel(req_sel), .req_len(req_len), .wr_data(wr_data),
        .hold(hold), .busy(busy), .beat_done(beat_done), .rd_data(rd_data), .rd_tag(rd_tag), .fault(fault));
    bus_slave_end u_bus_slave_end (.mclk(mclk), .rst_b(rst_b), .bus(bus_if.slave), .wait_cfg(wait_cfg),
        .wr_pulse(wr_pulse), .wr_adr(wr_adr));
    soc_bus_cycle_chk u_chk (.mclk(mclk), .rst_b(rst_b), .cyc(bus_if.cyc), .stb(bus_if.stb), .we(bus_if.we),
        .adr(bus_if.adr), .tag_m(bus_if.tag_m), .dat_m(bus_if.dat_m), .ack(bus_if.ack), .err(bus_if.err),
        .rty(bus_if.rty));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One whole cycle; gap holds the master off after the first beat for a few clocks
    task automatic run_op(input logic we, input logic [7:0] adr, input logic [7:0] len, input logic [3:0] sel,
                          input logic [31:0] data, input logic gap, input logic [3:0] wt);
        int i;
        rdq.delete();
        nwr = 0;
        @(posedge mclk);
        req <= 1'b1;
        req_we <= we;
        req_adr <= adr;
        req_len <= len;
        req_sel <= sel;
        wr_data <= data;
        hold <= gap;
        wait_cfg <= wt;
        @(posedge mclk);
        req <= 1'b0;
        for (i = 0; i < 300; i++) begin
            #1;
            if (beat_done === 1'b1) begin
                rdq.push_back(rd_data);
            end
            if (wr_pulse === 1'b1) begin
                check({24'h0, adr + nwr[7:0]}, {24'h0, wr_adr});
                nwr++;
            end
            if (busy !== 1'b1) break;
            @(posedge mclk);
            if (i == 4) hold <= 1'b0;
        end
        check(busy, 1'b0);
        @(posedge mclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_single();
        run_op(1'b1, 8'h10, 8'h01, 4'hf, 32'h1234abcd, 1'b0, 4'h0);
        check(nwr, 1);
        run_op(1'b1, 8'h10, 8'h01, 4'h1, 32'h000000ee, 1'b0, 4'h3);
        run_op(1'b0, 8'h10, 8'h01, 4'hf, 32'h0, 1'b0, 4'h1);
        check(rdq.size(), 1);
        check(rdq[0], 32'h1234abee);
        check(rd_tag, soc_bus_pkg::TAG_START);
        check(nwr, 0);
    endtask
    task automatic t_block();
        int i;
        run_op(1'b1, 8'h24, 8'h01, 4'hf, 32'h00000005, 1'b0, 4'h0);
        run_op(1'b1, 8'h20, 8'h04, 4'hf, 32'hcafe0001, 1'b1, 4'h2);
        check(nwr, 4);
        run_op(1'b0, 8'h20, 8'h05, 4'hf, 32'h0, 1'b0, 4'h0);
        check(rdq.size(), 5);
        for (i = 0; i < 4; i++) begin
            check(rdq[i], 32'hcafe0001);
        end
        check(rdq[4], 32'h00000005);
        run_op(1'b0, 8'h21, 8'h03, 4'hf, 32'h0, 1'b1, 4'h1);
        check(rdq[2], 32'hcafe0001);
    endtask
    // Reset in the middle of a slow read, then a clean read afterwards
    task automatic t_reset();
        @(posedge mclk);
        req <= 1'b1;
        req_we <= 1'b0;
        req_adr <= 8'h20;
        req_len <= 8'h02;
        hold <= 1'b0;
        wait_cfg <= 4'hf;
        @(posedge mclk);
        req <= 1'b0;
        @(posedge mclk);
        #1;
        check(busy, 1'b1);
        @(posedge mclk);
        rst_b <= 1'b0;
        #1;
        check(busy, 1'b0);
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        run_op(1'b0, 8'h24, 8'h01, 4'hf, 32'h0, 1'b0, 4'h0);
        check(rdq[0], 32'h00000005);
    endtask
    task automatic t_fault();
        run_op(1'b1, 8'hff, 8'h01, 4'hf, 32'h0, 1'b0, 4'h0);
        check(fault, 1'b1);
        check(nwr, 0);
        run_op(1'b0, 8'h10, 8'h01, 4'hf, 32'h0, 1'b0, 4'h0);
        check(fault, 1'b0);
    endtask
    // ----------------------------------------
    // Clock, main sequence, watchdog
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        rst_b = 1'b0;
        req = 1'b0;
        req_we = 1'b0;
        req_adr = 8'h00;
        req_sel = 4'hf;
        req_len = 8'h01;
        wr_data = 32'h0;
        hold = 1'b0;
        wait_cfg = 4'h0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        t_single();
        t_block();
        t_reset();
        t_fault();
        stop_test();
    end
    // Whole run needs well under a thousand clocks
    initial begin
        #50000;
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
`default_nettype wire
